//--- design/rsc_pkg.sv
// Constants and types shared by the signal-strength capture logic
package rsc_pkg;
	localparam int          RSC_CODE_W        = 3;
	localparam logic [7:0]  RSC_ADDR_CTRL     = 8'h00;
	localparam logic [7:0]  RSC_ADDR_LEVEL    = 8'h0F;
	localparam int          RSC_CTRL_EXT_SEL  = 1;
	localparam int          RSC_CTRL_TX_ON    = 5;
	localparam logic [7:0]  RSC_CTRL_RESET    = 8'h00;
	localparam logic [7:0]  RSC_CMD_RX_ENABLE = 8'h17;
	localparam logic [7:0]  RSC_CMD_MEAS_INT  = 8'h18;
	localparam logic [7:0]  RSC_CMD_MEAS_EXT  = 8'h19;
	localparam int          RSC_MAIN_LSB      = 0;
	localparam int          RSC_AUX_LSB       = 3;
	localparam int          RSC_OSC_BIT       = 6;
	localparam logic [2:0]  RSC_CODE_ZERO     = 3'h0;
	localparam logic [2:0]  RSC_CODE_MAX      = 3'h7;
	typedef enum {RSC_IDLE, RSC_INT, RSC_EXT} rsc_mode_t;
endpackage

//--- design/rsc_peak_hold.sv
// Peak-hold latch for one 3-bit level code
`timescale 1ns/1ns
module rsc_peak_hold
	import rsc_pkg::*;
#(
	parameter int WIDTH = RSC_CODE_W
) (
	input  wire logic             sys_clk,
	input  wire logic             reset,
	input  wire logic             clear,
	input  wire logic             track,
	input  wire logic [WIDTH-1:0] level,
	output logic      [WIDTH-1:0] peak
);
	typedef struct packed {
		logic [WIDTH-1:0] peak;
	} rsc_ph_state_t;

	rsc_ph_state_t state, next_state;

	initial begin
		if (WIDTH < 1) begin
			$error("rsc_peak_hold: WIDTH must be positive");
		end
	end

	always_comb begin
		next_state = state;
		if (clear) begin
			next_state.peak = '0;
		end else if (track && level > state.peak) begin
			next_state.peak = level;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign peak = state.peak;
endmodule // rsc_peak_hold

//--- design/rsc_capture.sv
// Signal-strength capture control: detectors, status byte and commands
// Overview of operation
// - Three independent level sources exist: internal main, internal auxiliary and external.
// - Each internal detector keeps the highest code seen during a receive packet.
// - Every reader transmission clears the stored codes.
// - Each internal result is a 3-bit code of seven steps of about 4 dB.
// - Main and auxiliary codes are both stored in the level register at 0x0F.
// - Bit 1 of control register 0x00 selects internal or external codes for the level register.
// - Command 0x18 starts an internal measurement.
// - The external detector gives a 3-bit carrier code stored in the level register.
// - Commands 0x18 and 0x19 request internal and external results into the level register.
// - A level register read returns a byte from 0x40 to 0x7F.
// - Reading the level register clears its stored codes.
`timescale 1ns/1ns
module rsc_capture
	import rsc_pkg::*;
#(
	parameter int CODE_W = RSC_CODE_W
) (
	input  wire logic              sys_clk,
	input  wire logic              reset,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	input  wire logic [7:0]        reg_addr,
	input  wire logic [7:0]        reg_wdata,
	input  wire logic              cmd_valid,
	input  wire logic [7:0]        cmd_code,
	input  wire logic              tx_active,
	input  wire logic              rx_packet,
	input  wire logic              osc_stable,
	input  wire logic [CODE_W-1:0] main_level,
	input  wire logic [CODE_W-1:0] aux_level,
	input  wire logic [CODE_W-1:0] ext_level,
	output logic [7:0]             reg_rdata,
	output logic                   rdata_valid,
	output logic                   tx_enable,
	output logic                   rx_enable
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [7:0]        ctrl;
		logic              rx_on;
		rsc_mode_t         mode;
		logic [CODE_W-1:0] main_code;
		logic [CODE_W-1:0] aux_code;
		logic [7:0]        rdata;
		logic              rvalid;
	} rsc_state_t;

	rsc_state_t        state, next_state;
	logic [CODE_W-1:0] main_peak;
	logic [CODE_W-1:0] aux_peak;
	logic              clear_codes;
	logic              rd_level;
	logic              int_track;
	logic              wr_ctrl;
	logic              rd_ctrl;
	logic              cmd_rx_on;
	logic              cmd_int;
	logic              cmd_ext;
	logic              cap_int;
	logic              cap_ext;
	logic [7:0]        level_byte;
	logic [7:0]        read_byte;

	// ------------------------------------------------------------
	// Elaboration checks
	// ------------------------------------------------------------
	initial begin
		if (CODE_W != RSC_CODE_W) begin
			$error("rsc_capture: level byte layout needs 3-bit codes");
		end
		// Fields of the level byte must not overlap
		if (RSC_AUX_LSB < RSC_MAIN_LSB + CODE_W) begin
			$error("rsc_capture: main and auxiliary fields overlap");
		end
		if (RSC_OSC_BIT < RSC_AUX_LSB + CODE_W) begin
			$error("rsc_capture: auxiliary field runs into the oscillator bit");
		end
		if (RSC_CTRL_EXT_SEL == RSC_CTRL_TX_ON) begin
			$error("rsc_capture: select and transmitter bits collide");
		end
	end

	// ------------------------------------------------------------
	// Access and command decode
	// ------------------------------------------------------------
	assign wr_ctrl   = reg_wr && reg_addr == RSC_ADDR_CTRL;
	assign rd_ctrl   = reg_rd && reg_addr == RSC_ADDR_CTRL;
	assign rd_level  = reg_rd && reg_addr == RSC_ADDR_LEVEL;
	assign cmd_rx_on = cmd_valid && cmd_code == RSC_CMD_RX_ENABLE;
	assign cmd_int   = cmd_valid && cmd_code == RSC_CMD_MEAS_INT;
	assign cmd_ext   = cmd_valid && cmd_code == RSC_CMD_MEAS_EXT;

	// ------------------------------------------------------------
	// Internal detectors
	// ------------------------------------------------------------
	assign clear_codes = tx_active || rd_level;
	// Tracks only while a packet arrives in an internal measurement
	assign int_track   = rx_packet && state.mode == RSC_INT;

	rsc_peak_hold #(.WIDTH(CODE_W)) u_main_peak (
		.sys_clk (sys_clk),
		.reset   (reset),
		.clear   (clear_codes),
		.track   (int_track),
		.level   (main_level),
		.peak    (main_peak)
	);

	rsc_peak_hold #(.WIDTH(CODE_W)) u_aux_peak (
		.sys_clk (sys_clk),
		.reset   (reset),
		.clear   (clear_codes),
		.track   (int_track),
		.level   (aux_level),
		.peak    (aux_peak)
	);

	// ------------------------------------------------------------
	// Capture qualifiers and read data
	// ------------------------------------------------------------
	// Internal codes only when the select bit picks them
	assign cap_int = state.mode == RSC_INT && !state.ctrl[RSC_CTRL_EXT_SEL];
	// External code needs the receiver on; transmitter state is the host's call
	assign cap_ext = state.mode == RSC_EXT && state.rx_on
		&& state.ctrl[RSC_CTRL_EXT_SEL];

	// Bit 6 tied high and bit 7 low keep every level read in 0x40 to 0x7F
	always_comb begin
		level_byte = 8'h00;
		level_byte[RSC_OSC_BIT] = 1'h1;
		level_byte[RSC_MAIN_LSB +: CODE_W] = state.main_code;
		level_byte[RSC_AUX_LSB +: CODE_W]  = state.aux_code;
	end

	// Unmapped addresses read as zero
	always_comb begin
		if (rd_level) begin
			read_byte = level_byte;
		end else if (rd_ctrl) begin
			read_byte = state.ctrl;
		end else begin
			read_byte = 8'h00;
		end
	end

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		next_state        = state;
		next_state.rvalid = 1'h0;
		if (wr_ctrl) begin
			next_state.ctrl = reg_wdata;
		end
		if (cmd_rx_on) begin
			next_state.rx_on = 1'h1;
		end
		if (cmd_int) begin
			next_state.mode = RSC_INT;
		end else if (cmd_ext) begin
			next_state.mode = RSC_EXT;
		end
		// Stored pair follows the source of the measurement mode, only while the select bit agrees
		case (state.mode)
			RSC_INT: begin
				if (cap_int) begin
					next_state.main_code = main_peak;
					next_state.aux_code  = aux_peak;
				end
			end
			RSC_EXT: begin
				if (cap_ext) begin
					next_state.main_code = ext_level;
					next_state.aux_code  = RSC_CODE_ZERO;
				end
			end
			// Idle keeps the pair; a command decoded above must still land
			default: begin
			end
		endcase
		if (reg_rd) begin
			next_state.rdata  = read_byte;
			next_state.rvalid = 1'h1;
		end
		// Clear last so a read never returns a half-cleared pair
		if (clear_codes) begin
			next_state.main_code = RSC_CODE_ZERO;
			next_state.aux_code  = RSC_CODE_ZERO;
			next_state.mode      = RSC_IDLE;
		end
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			state.ctrl      <= RSC_CTRL_RESET;
			state.rx_on     <= 1'b0;
			state.mode      <= RSC_IDLE;
			state.main_code <= RSC_CODE_ZERO;
			state.aux_code  <= RSC_CODE_ZERO;
			state.rdata     <= 8'h00;
			state.rvalid    <= 1'b0;
		end else begin
			state <= next_state;
		end
	end

	// ------------------------------------------------------------
	// Outputs, all straight from the state register
	// ------------------------------------------------------------
	assign reg_rdata   = state.rdata;
	assign rdata_valid = state.rvalid;
	assign tx_enable   = state.ctrl[RSC_CTRL_TX_ON];
	assign rx_enable   = state.rx_on;
endmodule // rsc_capture

//--- testbench/rsc_capture_props.sv
// Concurrent checks on the capture block ports
`timescale 1ns/1ns
module rsc_capture_props
	import rsc_pkg::*;
(
	input wire logic       sys_clk,
	input wire logic       reset,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       cmd_valid,
	input wire logic [7:0] cmd_code,
	input wire logic       tx_active,
	input wire logic [7:0] reg_rdata,
	input wire logic       rdata_valid,
	input wire logic       tx_enable,
	input wire logic       rx_enable
);
	// ----
	// Properties
	// ----
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);
	sequence s_rd;
		reg_rd && reg_addr == RSC_ADDR_LEVEL;
	endsequence
	property p_valid; s_rd |=> rdata_valid; endproperty
	a_valid: assert property (p_valid) else $error("no read strobe");
	property p_spur; !reg_rd |=> !rdata_valid; endproperty
	a_spur: assert property (p_spur) else $error("stray read strobe");
	property p_range; s_rd |=> reg_rdata[7:6] == 2'h1; endproperty
	a_range: assert property (p_range) else $error("level byte range");
	property p_hold; !reg_rd |=> $stable(reg_rdata); endproperty
	a_hold: assert property (p_hold) else $error("read data moved");
	property p_unmap; reg_rd && reg_addr > RSC_ADDR_LEVEL |=> reg_rdata == 8'h00; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read");
	// Mode drops to idle after a read, so a second read sees no codes
	property p_clear; s_rd ##1 !cmd_valid ##1 s_rd |=> reg_rdata[5:0] == 6'h00; endproperty
	a_clear: assert property (p_clear) else $error("read did not clear");
	property p_txclr; tx_active ##1 (s_rd and tx_active) |=> reg_rdata[5:0] == 6'h00; endproperty
	a_txclr: assert property (p_txclr) else $error("transmit did not clear");
	property p_txen; reg_wr && reg_addr == RSC_ADDR_CTRL |=> tx_enable == $past(reg_wdata[5]);
	endproperty
	a_txen: assert property (p_txen) else $error("transmitter bit");
	property p_rxen; cmd_valid && cmd_code == RSC_CMD_RX_ENABLE |=> rx_enable; endproperty
	a_rxen: assert property (p_rxen) else $error("receiver enable");
endmodule // rsc_capture_props

//--- testbench/rsc_host_model.sv
// Host controller model: register accesses and direct commands
`timescale 1ns/1ns
module rsc_host_model
	import rsc_pkg::*;
(
	input  wire logic  sys_clk,
	output logic       reg_wr,
	output logic       reg_rd,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic       cmd_valid,
	output logic [7:0] cmd_code
);
	initial begin
		{reg_wr, reg_rd, cmd_valid} = 3'h0;
		{reg_addr, reg_wdata, cmd_code} = 24'h0;
	end
	// One-cycle strobe; released lines show the inverse, not the old value
	task automatic op(input logic [1:0] k, input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_wr <= k == 2'h1;
		reg_rd <= k == 2'h2;
		cmd_valid <= k == 2'h3;
		reg_addr <= a;
		reg_wdata <= d;
		cmd_code <= d;
		@(posedge sys_clk);
		{reg_wr, reg_rd, cmd_valid} <= 3'h0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
		cmd_code <= ~d;
	endtask
endmodule // rsc_host_model

//--- testbench/rsc_capture_tb.sv
// Self-checking bench for the signal-strength capture block
`timescale 1ns/1ns
module rsc_capture_tb;
	import rsc_pkg::*;
	logic       sys_clk = 1'h0, reset = 1'h1, tx_active, rx_packet, osc_stable;
	logic       reg_wr, reg_rd, cmd_valid, rdata_valid, tx_enable, rx_enable;
	logic [7:0] reg_addr, reg_wdata, cmd_code, reg_rdata;
	logic [2:0] main_level, aux_level, ext_level;
	int         err_count = 0, num_checks = 0, mx, ax;
	int         exp_q[$];
	always #25 sys_clk = ~sys_clk;
	rsc_host_model HOST (.sys_clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .cmd_valid, .cmd_code);
	rsc_capture DUT (.sys_clk, .reset, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .cmd_valid,
		.cmd_code, .tx_active, .rx_packet, .osc_stable, .main_level, .aux_level, .ext_level,
		.reg_rdata, .rdata_valid, .tx_enable, .rx_enable);
	task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
		num_checks++;
		if (s !== e) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic rd(input logic [7:0] a, input int e);
		HOST.op(2'h2, a, 8'h00);
		#1;
		check("valid", {7'h0, rdata_valid}, 8'h01);
		check("rdata", reg_rdata, 8'(e));
	endtask
	// Model keeps the largest code driven while the packet runs
	task automatic burst();
		mx = 0;
		ax = 0;
		repeat (6) begin
			@(posedge sys_clk);
			rx_packet <= 1'h1;
			main_level <= 3'($urandom);
			aux_level <= 3'($urandom);
			osc_stable <= 1'($urandom);
			#1;
			mx = (main_level > mx) ? main_level : mx;
			ax = (aux_level > ax) ? aux_level : ax;
		end
		@(posedge sys_clk);
		rx_packet <= 1'h0;
		repeat (3) @(posedge sys_clk);
	endtask
	initial begin
		void'($urandom(56593));
		{tx_active, rx_packet, osc_stable, main_level, aux_level, ext_level} = 12'h0;
		repeat (16) @(posedge sys_clk);
		reset <= 1'h0;
		rd(8'h05, 0);
		HOST.op(2'h1, RSC_ADDR_CTRL, 8'h20);
		HOST.op(2'h3, 8'h00, RSC_CMD_RX_ENABLE);
		#1;
		check("tx_enable", {7'h0, tx_enable}, 8'h01);
		check("rx_enable", {7'h0, rx_enable}, 8'h01);
		rd(RSC_ADDR_CTRL, 8'h20);
		rd(8'h10 | 8'($urandom), 0);
		$display("control test done");
		repeat (3) begin
			HOST.op(2'h3, 8'h00, RSC_CMD_MEAS_INT);
			burst();
			exp_q.push_back(8'h40 | (ax << 3) | mx);
			rd(RSC_ADDR_LEVEL, exp_q.pop_front());
			rd(RSC_ADDR_LEVEL, 8'h40);
		end
		$display("internal test done");
		HOST.op(2'h3, 8'h00, RSC_CMD_MEAS_INT);
		burst();
		@(posedge sys_clk);
		tx_active <= 1'h1;
		rd(RSC_ADDR_LEVEL, 8'h40);
		@(posedge sys_clk);
		tx_active <= 1'h0;
		$display("transmit clear test done");
		HOST.op(2'h1, RSC_ADDR_CTRL, 8'h02);
		repeat (2) begin
			@(posedge sys_clk);
			ext_level <= 3'($urandom);
			HOST.op(2'h3, 8'h00, RSC_CMD_MEAS_EXT);
			repeat (3) @(posedge sys_clk);
			rd(RSC_ADDR_LEVEL, 8'h40 | ext_level);
		end
		$display("external test done");
		@(posedge sys_clk);
		reset <= 1'h1;
		repeat (2) @(posedge sys_clk);
		reset <= 1'h0;
		#1;
		check("tx_enable", {7'h0, tx_enable}, 8'h00);
		check("rx_enable", {7'h0, rx_enable}, 8'h00);
		check("rdata_valid", {7'h0, rdata_valid}, 8'h00);
		rd(RSC_ADDR_CTRL, 0);
		$display("reset test done");
		test_done();
	end
	initial begin
		repeat (5000) @(posedge sys_clk);
		err_count++;
		test_done();
	end
endmodule // rsc_capture_tb
bind rsc_capture rsc_capture_props PROPS (.sys_clk, .reset, .reg_wr, .reg_rd, .reg_addr,
	.reg_wdata, .cmd_valid, .cmd_code, .tx_active, .reg_rdata, .rdata_valid, .tx_enable,
	.rx_enable);
